/* File: timer_block_defs.svh */
// register map, field positions and reset values of the timer channel block
// Function
// - enabled compare match or capture strobe inverts the output flip-flop
// - output flip-flop level after reset must not be relied on
// - init field write: 01 sets, 10 clears, 00 inverts the flip-flop
// - flip-flop value is driven to the timer output pin
// - run bit 7 enables double buffering of compare register zero
// - run bit 3 keeps the timer running during idle low-power state
// - run bit 2 runs or stops the channel prescaler
// - run bit 0 lets counter count; cleared stops and clears it
// - run bits 1, 4 and 5 hold no function on read
// - writing 0 to mode bit 5 captures counter into capture register 0
// - code 10 uses rise/fall of input 0, code 11 of other timer
// - fourth channel has no pins: codes 01 and 10 leave capture disabled
// - mode bit 2 clears counter on compare-1 match, else free running
// - mode bits 1:0 select counter clock: pin, fine, div4, div16 tap
// - software capture into register 0 also counts as capture-0 toggle
// - both match-toggle enables set invert on compare-0 and compare-1
// - each comparator match raises its own interrupt request
`ifndef TIMER_BLOCK_DEFS_SVH
`define TIMER_BLOCK_DEFS_SVH
// printed register indices; byte address is four times the index
`define CH0_RUN_IDX 32'hFFFFF180
`define CH0_MOD_IDX 32'hFFFFF182
`define CH1_RUN_IDX 32'hFFFFF190
`define CH1_MOD_IDX 32'hFFFFF192
`define CH2_RUN_IDX 32'hFFFFF1A0
`define CH2_MOD_IDX 32'hFFFFF1A2
`define CH3_RUN_IDX 32'hFFFFF1B0
`define CH3_MOD_IDX 32'hFFFFF1B2
// index decode: idx[11:6] block, idx[5:4] channel, idx[3:0] register
`define BLK_IDX 6'h06
`define SUB_RUN 4'h0
`define SUB_MOD 4'h2
`define SUB_FFC 4'h4
`define SUB_STA 4'h6
// run register fields
`define RUN_DBUF 7
`define RUN_RSV6 6
`define RUN_IDLE 3
`define RUN_PRESC 2
`define RUN_RUN 0
`define RUN_RST 8'h00
// mode register fields
`define MOD_HI 7:6
`define MOD_SOFT 5
`define MOD_CPM 4:3
`define MOD_CLE 2
`define MOD_CLK 1:0
`define MOD_RST 8'h20
// flop control register fields
`define FFC_EN 5:2
`define FFC_CMD 1:0
`define FFC_EN_RST 4'h0
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: timer_block_pkg.sv */
// types shared by the timer channel block
`default_nettype none
package timer_block_pkg;
  typedef enum logic [1:0] {
    CAP_OFF = 2'b00,
    CAP_PINS = 2'b01,
    CAP_IN0 = 2'b10,
    CAP_OTHER = 2'b11
  } capture_mode_t;
  typedef enum logic [1:0] {
    CLK_PIN = 2'b00,
    CLK_FINE = 2'b01,
    CLK_DIV4 = 2'b10,
    CLK_DIV16 = 2'b11
  } clock_sel_t;
  typedef enum logic [1:0] {
    FF_INVERT = 2'b00,
    FF_SET = 2'b01,
    FF_CLEAR = 2'b10,
    FF_KEEP = 2'b11
  } flop_cmd_t;
endpackage : timer_block_pkg
`default_nettype wire

/* File: timer_block.sv */
// four timer channel control slices behind an axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_defs.svh"

module timer_channel import timer_block_pkg::*; #(
  parameter bit HAS_PINS = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register writes
  input wire logic wrRun,
  input wire logic wrMode,
  input wire logic wrFfc,
  input wire logic [7:0] wrData,
  // event sources
  input wire logic inZero,
  input wire logic inOne,
  input wire logic otherOut,
  input wire logic match0,
  input wire logic match1,
  input wire logic tapFine,
  input wire logic tapDiv4,
  input wire logic tapDiv16,
  input wire logic idleMode,
  // register views
  output logic [7:0] runView,
  output logic [7:0] modeView,
  output logic [7:0] ffcView,
  // control outputs
  output logic outPin,
  output logic dbufEnable,
  output logic prescRun,
  output logic countRun,
  output logic countClear,
  output logic countTick,
  output logic capture0,
  output logic capture1,
  output logic match0Irq,
  output logic match1Irq
);
  logic dbuf_q, rsv6_q, idle_q, presc_q, run_q;
  logic [1:0] modeHi_q;
  capture_mode_t capSel_q;
  logic clrMatch_q;
  clock_sel_t clkSel_q;
  logic [3:0] ffEn_q;
  logic flop_q;
  logic in0Prev_q, in1Prev_q, othPrev_q;
  logic softCap, trig0, trig1, tickSel, toggle;
  flop_cmd_t cmd;

  // run register; bit 6 stored as written, software keeps it 0
  always_ff @(posedge clk) begin
    if (reset) begin
      {dbuf_q, rsv6_q, idle_q, presc_q, run_q} <= 5'h00;
    end else if (wrRun) begin
      dbuf_q <= wrData[`RUN_DBUF];
      rsv6_q <= wrData[`RUN_RSV6];
      idle_q <= wrData[`RUN_IDLE];
      presc_q <= wrData[`RUN_PRESC];
      run_q <= wrData[`RUN_RUN];
    end
  end

  // mode register; soft capture bit is a command, not stored
  always_ff @(posedge clk) begin
    if (reset) begin
      modeHi_q <= 2'h0;
      capSel_q <= CAP_OFF;
      clrMatch_q <= 1'b0;
      clkSel_q <= CLK_PIN;
    end else if (wrMode) begin
      modeHi_q <= wrData[`MOD_HI];
      capSel_q <= capture_mode_t'(wrData[`MOD_CPM]);
      clrMatch_q <= wrData[`MOD_CLE];
      clkSel_q <= clock_sel_t'(wrData[`MOD_CLK]);
    end
  end

  // toggle enables of the flop control register
  always_ff @(posedge clk) begin
    if (reset) begin
      ffEn_q <= `FFC_EN_RST;
    end else if (wrFfc) begin
      ffEn_q <= wrData[`FFC_EN];
    end
  end

  // previous input levels for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      {in0Prev_q, in1Prev_q, othPrev_q} <= 3'h0;
    end else begin
      in0Prev_q <= inZero;
      in1Prev_q <= inOne;
      othPrev_q <= otherOut;
    end
  end

  // capture trigger decode; pinless channel ignores pin codes
  always_comb begin
    softCap = wrMode & ~wrData[`MOD_SOFT];
    trig0 = 1'b0;
    trig1 = 1'b0;
    case (capSel_q)
      CAP_OFF: trig0 = 1'b0;
      CAP_PINS: begin
        trig0 = HAS_PINS & inZero & ~in0Prev_q;
        trig1 = HAS_PINS & inOne & ~in1Prev_q;
      end
      CAP_IN0: begin
        trig0 = HAS_PINS & inZero & ~in0Prev_q;
        trig1 = HAS_PINS & ~inZero & in0Prev_q;
      end
      CAP_OTHER: begin
        trig0 = otherOut & ~othPrev_q;
        trig1 = ~otherOut & othPrev_q;
      end
      default: trig0 = 1'b0;
    endcase
  end

  // count clock select, gated by run and idle hold
  always_comb begin
    case (clkSel_q)
      CLK_PIN: tickSel = HAS_PINS & inZero & ~in0Prev_q;
      CLK_FINE: tickSel = tapFine;
      CLK_DIV4: tickSel = tapDiv4;
      CLK_DIV16: tickSel = tapDiv16;
      default: tickSel = 1'b0;
    endcase
  end

  // each enabled event inverts once; simultaneous events cancel pairwise
  always_comb begin
    toggle = (ffEn_q[0] & match0) ^ (ffEn_q[1] & match1)
      ^ (ffEn_q[2] & (trig0 | softCap)) ^ (ffEn_q[3] & trig1);
    cmd = wrFfc ? flop_cmd_t'(wrData[`FFC_CMD]) : FF_KEEP;
  end

  // output flop; forced to 0 at reset only to keep the pin defined
  always_ff @(posedge clk) begin
    if (reset) begin
      flop_q <= 1'b0;
    end else begin
      case (cmd)
        FF_SET: flop_q <= 1'b1;
        FF_CLEAR: flop_q <= 1'b0;
        FF_INVERT: flop_q <= ~flop_q ^ toggle;
        FF_KEEP: flop_q <= flop_q ^ toggle;
        default: flop_q <= flop_q;
      endcase
    end
  end

  // registered control outputs, one cycle behind their causes
  always_ff @(posedge clk) begin
    if (reset) begin
      countClear <= 1'b1;
      countTick <= 1'b0;
      capture0 <= 1'b0;
      capture1 <= 1'b0;
      match0Irq <= 1'b0;
      match1Irq <= 1'b0;
    end else begin
      countClear <= ~run_q | (clrMatch_q & match1);
      countTick <= run_q & tickSel & (idle_q | ~idleMode);
      capture0 <= trig0 | softCap;
      capture1 <= trig1;
      match0Irq <= match0;
      match1Irq <= match1;
    end
  end

  // views and level outputs taken from the stored registers
  always_comb begin
    runView = {dbuf_q, rsv6_q, 2'b00, idle_q, presc_q, 1'b0, run_q};
    modeView = {modeHi_q, 1'b1, capSel_q, clrMatch_q, clkSel_q};
    ffcView = {2'b11, ffEn_q, 2'b11};
    outPin = flop_q;
    dbufEnable = dbuf_q;
    prescRun = presc_q;
    countRun = run_q;
  end

  property p_set;
    @(posedge clk) disable iff (reset) (wrFfc && wrData[`FFC_CMD] == FF_SET) |=> flop_q;
  endproperty
  a_set: assert property (p_set) else $error("flop not set");
  property p_clear;
    @(posedge clk) disable iff (reset) (wrFfc && wrData[`FFC_CMD] == FF_CLEAR) |=> !flop_q;
  endproperty
  a_clear: assert property (p_clear) else $error("flop not cleared");
  property p_match_toggle;
    @(posedge clk) disable iff (reset)
      (!wrFfc && ffEn_q[0] && match0 && !match1 && !capture0 && !trig0 && !trig1 && !softCap)
      |=> flop_q != $past(flop_q);
  endproperty
  a_match_toggle: assert property (p_match_toggle) else $error("match did not toggle");
  property p_hold;
    @(posedge clk) disable iff (reset) (!wrFfc && !toggle) |=> $stable(flop_q);
  endproperty
  a_hold: assert property (p_hold) else $error("flop changed without cause");
  property p_stop_clear;
    @(posedge clk) disable iff (reset) (wrRun && !wrData[`RUN_RUN]) |=> ##1 (countClear && !countTick);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not cleared");
  property p_match_clear;
    @(posedge clk) disable iff (reset) (clrMatch_q && match1) |=> countClear;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("no clear on match");
  property p_soft;
    @(posedge clk) disable iff (reset) (wrMode && !wrData[`MOD_SOFT]) |=> capture0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft capture missing");
  property p_fall;
    @(posedge clk) disable iff (reset)
      (HAS_PINS && capSel_q == CAP_IN0 && $fell(inZero)) |=> capture1;
  endproperty
  a_fall: assert property (p_fall) else $error("falling capture missing");
  property p_nopins;
    @(posedge clk) disable iff (reset)
      (!HAS_PINS && (capSel_q == CAP_PINS || capSel_q == CAP_IN0) && !softCap) |=> !capture0 && !capture1;
  endproperty
  a_nopins: assert property (p_nopins) else $error("pinless capture fired");
  property p_irq;
    @(posedge clk) disable iff (reset) match0 |=> match0Irq ##0 $past(match0);
  endproperty
  a_irq: assert property (p_irq) else $error("match irq missing");
endmodule : timer_channel

module timer_block import timer_block_pkg::*; #(
  parameter int CHANNELS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // event inputs, per channel except the shared otherTimerOut and idleMode
  input wire logic [3:0] inZero,
  input wire logic [3:0] inOne,
  input wire logic otherTimerOut,
  input wire logic [3:0] match0,
  input wire logic [3:0] match1,
  input wire logic [3:0] tapFine,
  input wire logic [3:0] tapDiv4,
  input wire logic [3:0] tapDiv16,
  input wire logic idleMode,
  // per-channel outputs
  output logic [3:0] timerOutPin,
  output logic [3:0] dbufEnable,
  output logic [3:0] prescRun,
  output logic [3:0] countRun,
  output logic [3:0] countClear,
  output logic [3:0] countTick,
  output logic [3:0] capture0,
  output logic [3:0] capture1,
  output logic [3:0] match0Irq,
  output logic [3:0] match1Irq
);
  logic awHeld_q, wHeld_q;
  logic [13:0] awAddr_q;
  logic [7:0] wByte_q, rdByte;
  logic wLane_q;
  logic doWrite, wrHit, rdHit;
  logic [3:0] wrRun, wrMode, wrFfc;
  logic [7:0] runView [4];
  logic [7:0] modeView [4];
  logic [7:0] ffcView [4];

  if (CHANNELS != 4) begin : g_check
    $error("timer_block serves exactly four channels");
  end

  // write channels taken independently, answered once both are held
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 14'h0000;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr[13:0];
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
        wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // write decode; a write with lane 0 off changes nothing
  always_comb begin
    doWrite = awHeld_q & wHeld_q & ~bvalid;
    wrHit = awAddr_q[13:8] == `BLK_IDX &&
      (awAddr_q[5:2] == `SUB_RUN || awAddr_q[5:2] == `SUB_MOD || awAddr_q[5:2] == `SUB_FFC ||
       awAddr_q[5:2] == `SUB_STA);
    for (int i = 0; i < 4; i++) begin
      wrRun[i] = doWrite && wLane_q && wrHit && awAddr_q[7:6] == 2'(i) && awAddr_q[5:2] == `SUB_RUN;
      wrMode[i] = doWrite && wLane_q && wrHit && awAddr_q[7:6] == 2'(i) && awAddr_q[5:2] == `SUB_MOD;
      wrFfc[i] = doWrite && wLane_q && wrHit && awAddr_q[7:6] == 2'(i) && awAddr_q[5:2] == `SUB_FFC;
    end
  end

  // read mux over the addressed channel
  always_comb begin
    rdHit = araddr[13:8] == `BLK_IDX;
    case (araddr[5:2])
      `SUB_RUN: rdByte = runView[araddr[7:6]];
      `SUB_MOD: rdByte = modeView[araddr[7:6]];
      `SUB_FFC: rdByte = ffcView[araddr[7:6]];
      `SUB_STA: rdByte = {7'h00, timerOutPin[araddr[7:6]]};
      default: begin
        rdByte = 8'h00;
        rdHit = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rdHit ? rdByte : 8'h00};
      rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // identical slices; the last one has no capture pins
  for (genvar i = 0; i < 4; i++) begin : g_chan
    timer_channel #(.HAS_PINS(i != 3)) u_chan (
      .clk(clk), .reset(reset),
      .wrRun(wrRun[i]), .wrMode(wrMode[i]),
      .wrFfc(wrFfc[i]), .wrData(wByte_q),
      .inZero(inZero[i]), .inOne(inOne[i]),
      .otherOut(otherTimerOut), .match0(match0[i]),
      .match1(match1[i]), .tapFine(tapFine[i]),
      .tapDiv4(tapDiv4[i]), .tapDiv16(tapDiv16[i]),
      .idleMode(idleMode), .runView(runView[i]),
      .modeView(modeView[i]), .ffcView(ffcView[i]),
      .outPin(timerOutPin[i]), .dbufEnable(dbufEnable[i]),
      .prescRun(prescRun[i]), .countRun(countRun[i]),
      .countClear(countClear[i]), .countTick(countTick[i]),
      .capture0(capture0[i]), .capture1(capture1[i]),
      .match0Irq(match0Irq[i]), .match1Irq(match1Irq[i])
    );
  end
endmodule : timer_block
`default_nettype wire

/* File: timer_far_side.sv */
// far side model: capture trigger pins and output pin observer
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wanted pin levels and pacing
  input wire logic [3:0] wantZero,
  input wire logic [3:0] wantOne,
  input wire logic wantOther,
  input wire logic slow,
  // pins toward the block
  output logic [3:0] inZero,
  output logic [3:0] inOne,
  output logic otherTimerOut,
  // output pin watch
  input wire logic [3:0] timerOutPin,
  output logic [3:0][7:0] toggles
);
  logic [3:0] zeroA_q, zeroB_q, oneA_q, oneB_q, pinLast_q;
  logic otherA_q, otherB_q;
  logic [3:0][7:0] toggles_q;
  // pins follow the wanted levels one or two cycles late; slow only changes while idle
  always_ff @(posedge clk) begin
    zeroA_q <= wantZero;
    zeroB_q <= zeroA_q;
    oneA_q <= wantOne;
    oneB_q <= oneA_q;
    otherA_q <= wantOther;
    otherB_q <= otherA_q;
  end
  assign inZero = slow ? zeroB_q : zeroA_q;
  assign inOne = slow ? oneB_q : oneA_q;
  assign otherTimerOut = slow ? otherB_q : otherA_q;
  // count every change seen on each output pin
  always_ff @(posedge clk) begin
    pinLast_q <= timerOutPin;
    for (int i = 0; i < 4; i++) begin
      if (reset) begin
        toggles_q[i] <= 8'h00;
      end else if (timerOutPin[i] !== pinLast_q[i]) begin
        toggles_q[i] <= toggles_q[i] + 8'h01;
      end
    end
  end
  assign toggles = toggles_q;
endmodule : timer_far_side
`default_nettype wire

/* File: timer_channel_flop_and_control_test.sv */
// self-checking bench for the four timer channel control slices
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_defs.svh"
module timer_channel_flop_and_control_test import timer_block_pkg::*; ;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, wantZero, wantOne, inZero, inOne, match0, match1, tapFine, tapDiv4, tapDiv16;
  logic [1:0] bresp, rresp;
  logic wantOther, otherTimerOut, idleMode, slow;
  logic [3:0] timerOutPin, dbufEnable, prescRun, countRun, countClear, countTick;
  logic [3:0] capture0, capture1, match0Irq, match1Irq;
  logic [3:0][7:0] toggles, togSnap;
  int cnt[6][4];
  int snap[6][4];
  int errorCnt = 0;
  int testsRun = 0;
  timer_block #(.CHANNELS(4)) dut (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .inZero, .inOne, .otherTimerOut, .match0, .match1, .tapFine, .tapDiv4, .tapDiv16, .idleMode,
    .timerOutPin, .dbufEnable, .prescRun, .countRun, .countClear, .countTick, .capture0, .capture1,
    .match0Irq, .match1Irq);
  timer_far_side far (.clk, .reset, .wantZero, .wantOne, .wantOther, .slow, .inZero, .inOne,
    .otherTimerOut, .timerOutPin, .toggles);
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pulse tallies; nonblocking so snapshots never race the count
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[0][i] <= cnt[0][i] + (capture0[i] === 1'b1);
      cnt[1][i] <= cnt[1][i] + (capture1[i] === 1'b1);
      cnt[2][i] <= cnt[2][i] + (countTick[i] === 1'b1);
      cnt[3][i] <= cnt[3][i] + (match0Irq[i] === 1'b1);
      cnt[4][i] <= cnt[4][i] + (match1Irq[i] === 1'b1);
      cnt[5][i] <= cnt[5][i] + (countClear[i] === 1'b1);
    end
  end
  function automatic logic [31:0] adr(input int ch, input int sub);
    logic [31:0] idx;
    idx = `CH0_RUN_IDX + 32'(ch * 16 + sub);
    return idx << 2;
  endfunction : adr
  // only the documented run bits read back; bit 6 as written
  function automatic logic [31:0] expRun(input logic [7:0] d);
    return {24'h0, d & 8'hCD};
  endfunction : expRun
  function automatic logic flopNext(input logic cur, input logic [1:0] cmd);
    return (cmd == 2'b01) ? 1'b1 : (cmd == 2'b10) ? 1'b0 : (cmd == 2'b00) ? ~cur : cur;
  endfunction : flopNext
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
  // one-cycle event on one channel (the other-timer event reaches all), then time for it to settle
  task automatic ev(input int w, input int ch);
    logic [3:0] m;
    m = 4'h1 << ch;
    @(posedge clk);
    case (w)
      0: match0 <= m;
      1: match1 <= m;
      2: tapFine <= m;
      3: tapDiv4 <= m;
      4: tapDiv16 <= m;
      5: wantZero <= m;
      6: wantOne <= m;
      default: wantOther <= 1'b1;
    endcase
    @(posedge clk);
    {match0, match1, tapFine, tapDiv4, tapDiv16, wantZero, wantOne} <= '0;
    wantOther <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : ev
  task automatic take();
    snap = cnt;
    togSnap = toggles;
  endtask : take
  task automatic dl(input int k, input int ch, input int e);
    chk(cnt[k][ch] - snap[k][ch], e);
  endtask : dl
  task automatic tg(input int ch, input int e);
    chk(8'(toggles[ch] - togSnap[ch]), e);
  endtask : tg
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the expected few thousand cycles
  initial begin
    #(100 * 20000);
    errorCnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    int ch, c, e, d, md;
    logic [31:0] rv;
    logic [1:0] rs;
    logic cur;
    logic [1:0] cmdSeq [5];
    cmdSeq = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b11};
    {awvalid, wvalid, bready, arvalid, rready, wantOther, idleMode, slow} = '0;
    {awaddr, wdata, araddr} = '0;
    {wantZero, wantOne, match0, match1, tapFine, tapDiv4, tapDiv16} = '0;
    wstrb = 4'hF;
    reset = 1'b1;
    void'($urandom(32'hFA3D));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (ch = 0; ch < 4; ch++) begin
      rd(adr(ch, `SUB_RUN), rv, rs);
      chk(rv, 32'h00);
      rd(adr(ch, `SUB_MOD), rv, rs);
      chk(rv, 32'h20);
    end
    chk({dbufEnable, prescRun, countRun, countClear}, 16'h000F);
    // random run and mode values; bit 6 and mode bits 7:6 kept at 0 by software
    repeat (12) begin
      ch = $urandom % 4;
      d = $urandom & 8'hBF;
      md = ($urandom & 8'h1F) | 8'h20;
      slow <= 1'($urandom % 2);
      wr(adr(ch, `SUB_RUN), d[7:0], rs);
      rd(adr(ch, `SUB_RUN), rv, rs);
      chk(rv, expRun(d[7:0]));
      chk({dbufEnable[ch], prescRun[ch], countRun[ch], countClear[ch]}, {d[7], d[2], d[0], ~d[0]});
      wr(adr(ch, `SUB_MOD), md[7:0], rs);
      rd(adr(ch, `SUB_MOD), rv, rs);
      chk(rv, 32'(md));
    end
    for (ch = 0; ch < 4; ch++) begin
      wr(adr(ch, `SUB_RUN), 8'h00, rs);
      cur = 1'b0;
      foreach (cmdSeq[k]) begin
        wr(adr(ch, `SUB_FFC), 8'hC0 | cmdSeq[k], rs);
        cur = flopNext(cur, cmdSeq[k]);
        chk(timerOutPin[ch], cur);
        rd(adr(ch, `SUB_STA), rv, rs);
        chk(rv, 32'(cur));
      end
      // match toggles on, then off with the request still raised
      wr(adr(ch, `SUB_FFC), 8'hCF, rs);
      take();
      ev(0, ch);
      ev(1, ch);
      wr(adr(ch, `SUB_FFC), 8'hC3, rs);
      ev(0, ch);
      dl(3, ch, 2);
      dl(4, ch, 1);
      tg(ch, 2);
      // every capture code against every trigger source
      wr(adr(ch, `SUB_FFC), 8'hF3, rs);
      for (c = 0; c < 4; c++) begin
        wr(adr(ch, `SUB_MOD), 8'(8'h21 | (c << 3)), rs);
        take();
        ev(5, ch);
        ev(6, ch);
        ev(7, ch);
        e = (c == 3 || (c != 0 && ch < 3));
        dl(0, ch, e);
        dl(1, ch, e);
        tg(ch, 2 * e);
      end
      // software capture with only the capture-0 toggle enabled
      wr(adr(ch, `SUB_FFC), 8'hD3, rs);
      rd(adr(ch, `SUB_FFC), rv, rs);
      chk(rv, 32'hD3);
      take();
      wr(adr(ch, `SUB_MOD), 8'h01, rs);
      repeat (3) @(posedge clk);
      dl(0, ch, 1);
      tg(ch, 1);
      rd(adr(ch, `SUB_MOD), rv, rs);
      chk(rv, 32'h21);
      // each clock source; only the selected tap may tick
      wr(adr(ch, `SUB_RUN), 8'h05, rs);
      for (c = 0; c < 4; c++) begin
        wr(adr(ch, `SUB_MOD), 8'(8'h20 | c), rs);
        take();
        for (int k = 2; k < 6; k++) ev(k, ch);
        dl(2, ch, (c == 0 && ch == 3) ? 0 : 1);
      end
      // the divide-by-16 tap is still the selected clock here
      idleMode <= 1'b1;
      take();
      ev(4, ch);
      dl(2, ch, 0);
      wr(adr(ch, `SUB_RUN), 8'h0D, rs);
      take();
      ev(4, ch);
      dl(2, ch, 1);
      idleMode <= 1'b0;
      wr(adr(ch, `SUB_MOD), 8'h25, rs);
      take();
      ev(1, ch);
      dl(5, ch, 1);
      wr(adr(ch, `SUB_MOD), 8'h21, rs);
      take();
      ev(1, ch);
      dl(5, ch, 0);
      wr(adr(ch, `SUB_RUN), 8'h04, rs);
      take();
      ev(2, ch);
      dl(2, ch, 0);
    end
    // unmapped slot inside the channel window
    wr(adr(0, 8), 8'h55, rs);
    chk(rs, `RESP_SLVERR);
    rd(adr(0, 8), rv, rs);
    chk(rs, `RESP_SLVERR);
    chk(rv, 32'h0);
    end_of_test();
  end
endmodule : timer_channel_flop_and_control_test
`default_nettype wire
